/* common/sfsr_pkg.sv */
// Purpose: shared constants of the stepper fault status block
// Assumes: 16-bit serial frames, register data in frame bits 10..1
// Notes: status positions are given as frame bit numbers, field positions as data bit numbers
package sfsr_pkg;
    localparam int FRAME_BITS = 16;
    localparam int HEAD_BITS = 5;
    localparam int CNT_W = 5;
    // status word positions
    localparam int ST_FF = 15;
    localparam int ST_POR = 14;
    localparam int ST_SE = 13;
    localparam int ST_CR = 12;
    localparam int ST_SSA = 11;
    localparam int ST_OT = 10;
    localparam int ST_TW = 9;
    localparam int ST_OV = 8;
    localparam int ST_UV = 7;
    localparam int ST_OLB = 4;
    localparam int ST_OLA = 3;
    localparam int ST_OCB = 2;
    localparam int ST_OCA = 1;
    // latch vector: [5:0] monitors ot,tw,ov,uv,olb,ola ; [13:6] switch bits aph..bml
    localparam int MON_N = 6;
    localparam int SW_N = 8;
    localparam int LATCH_N = 14;
    localparam int LAT_UV = 2;
    // register addresses
    localparam logic [3:0] ADDR_FAULT_INDICATOR_PIN_CFG = 4'h3;
    localparam logic [3:0] ADDR_STEP_CTL = 4'h5;
    localparam logic [3:0] ADDR_SYS_CTL = 4'h6;
    localparam logic [3:0] ADDR_PROF_LO = 4'h7;
    localparam logic [3:0] ADDR_PROF_HI = 4'hc;
    localparam logic [3:0] ADDR_READBACK = 4'hd;
    localparam logic [3:0] ADDR_MASK = 4'he;
    localparam logic [3:0] ADDR_FAULT_INDICATOR_PIN = 4'hf;
    // field positions inside the 10-bit data (frame bit minus one)
    localparam int F_SLEEP = 9;
    localparam int F_FCLR = 8;
    localparam int F_CORD = 3;
    localparam int F_DSEL_HI = 9;
    localparam int F_DSEL_LO = 7;
    localparam logic [2:0] DSEL_SEQ = 3'h6;
    // reset values
    localparam logic [9:0] RST_CUR_CFG = 10'h270;
    localparam logic [9:0] RST_FAULT_INDICATOR_PIN_CFG = 10'h011;
    localparam logic [9:0] RST_SYS_CTL = 10'h020;
    localparam logic [9:0] RST_OTHER = 10'h000;
    localparam logic [3:0] ADDR_CUR_CFG = 4'h2;
    // timing
    localparam int CLK_NS = 10;
    localparam int RST_PULSE_NS = 1000;
    localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RST_CNT_W = 8;
endpackage

/* common/sfsr_latch_if.sv */
// Purpose: carrier between the top and the fault latch
// Assumes: one clock domain
// Notes: raw is the live fault level, clr a per-bit clear strobe
`timescale 1ns/1ps
`default_nettype none
interface sfsr_latch_if #(parameter int N = 14);
    logic [N-1:0] raw;
    logic [N-1:0] mask;
    logic [N-1:0] clr;
    logic [N-1:0] q;
    modport owner(output raw, output mask, output clr, input q);
    modport latch(input raw, input mask, input clr, output q);
endinterface
`default_nettype wire

/* rtl/sfsr_fault_latch.sv */
// Purpose: sticky fault bits with masking and presence-aware clear
// Assumes: raw faults already synchronised
// Notes: a fault still present survives any clear
`timescale 1ns/1ps
`default_nettype none
module sfsr_fault_latch #(
    parameter int N = 14,
    parameter logic [N-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // fault group
    sfsr_latch_if.latch lat
);
    logic [N-1:0] live;

    // masked faults never reach the latch
    assign live = lat.raw & ~lat.mask;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            lat.q <= RST_VAL;
        end else begin
            // set wins over clear, present faults stay
            lat.q <= (lat.q & ~lat.clr) | live;
        end
    end
endmodule
`default_nettype wire

/* rtl/sfsr_top.sv */
// Contract
// - every frame shifts out the five top status bits first
// - write frame writes register, returns low ten status bits plus parity
// - read frame returns addressed register plus parity, writes nothing
// - status layout: critical top three, sequencer 12-11, monitors, phase summary
// - summary flag is or of fault bits, excluding accept and active flags
// - summary flag appears when select falls; idle clock abandons frame cleanly
// - select high ends transfer and releases serial output
// - reset sets summary, power-up and undervoltage flags, clears rest, defaults registers
// - undervoltage reads set after reset
// - bit 13 reports previous transfer failed
// - accept flag reported; profile commands ignored while it is low
// - active flag follows programmed sequence start and completion
// - pin select 110 shows active flag on indicator, else summary
// - monitor bits latch; clear keeps faults still present
// - per-switch overcurrent bits feed phase a and b summaries
// - phase summaries clear only with diagnostic contents
// - writes to diagnostic register ignored, status low bits returned
// - reads clear latched faults unless clear-on-read disabled
// - fault reset by reset pulse or clear command clears faults
// - sleep by reset hold or sleep command clears faults
// - clear command acts only on rising transition
// - frames carry odd parity in last bit, generated not stored
// - masked faults produce no flag or diagnostic bit
//
// Purpose: status/diagnostic register bank behind the serial link
// Assumes: monitor and sequencer inputs are on sys_clk; link pins asynchronous
// Notes: link clock is sampled, so it must stay well below sys_clk/4
`timescale 1ns/1ps
`default_nettype none
module sfsr_top #(
    parameter int RST_CYC = sfsr_pkg::RST_PULSE_CYC
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // serial link pins
    input wire logic frame_select_n_i,
    input wire logic serial_clk_i,
    input wire logic serial_in_i,
    output logic serial_out_o,
    output logic serial_out_oe_n_o,
    // reset pin
    input wire logic hw_reset_input_low_i,
    // monitors: ot, tw, ov, uv, olb, ola
    input wire logic [sfsr_pkg::MON_N-1:0] monitor_fault_i,
    // switches: aph, apl, amh, aml, bph, bpl, bmh, bml
    input wire logic [sfsr_pkg::SW_N-1:0] switch_oc_i,
    // sequencer
    input wire logic command_accept_i,
    input wire logic sequence_active_i,
    output logic profile_write_o,
    // indicator pin
    output logic fault_indicator_pin_o
);
    ////////////////////////////////////////////////////////////////////////
    // link synchronisers
    logic [2:0] cs_sync;
    logic [2:0] sck_sync;
    logic [1:0] sdi_sync;
    logic [1:0] rstn_sync;
    logic cs_fall;
    logic cs_rise;
    logic sck_rise;
    logic sck_fall;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            cs_sync <= 3'h7;
            sck_sync <= 3'h0;
            sdi_sync <= 2'h0;
            rstn_sync <= 2'h3;
        end else begin
            cs_sync <= {cs_sync[1:0], frame_select_n_i};
            sck_sync <= {sck_sync[1:0], serial_clk_i};
            sdi_sync <= {sdi_sync[0], serial_in_i};
            rstn_sync <= {rstn_sync[0], hw_reset_input_low_i};
        end
    end

    assign cs_fall = cs_sync[2] & ~cs_sync[1];
    assign cs_rise = ~cs_sync[2] & cs_sync[1];
    assign sck_rise = ~cs_sync[1] & ~sck_sync[2] & sck_sync[1];
    assign sck_fall = ~cs_sync[1] & sck_sync[2] & ~sck_sync[1];

    ////////////////////////////////////////////////////////////////////////
    // register storage
    logic [9:0] regs [0:15];
    logic [9:0] mask_reg;
    logic [2:0] dsel;
    logic cord_dis;

    assign mask_reg = regs[sfsr_pkg::ADDR_MASK];
    assign dsel = regs[sfsr_pkg::ADDR_FAULT_INDICATOR_PIN_CFG][sfsr_pkg::F_DSEL_HI:sfsr_pkg::F_DSEL_LO];
    assign cord_dis = regs[sfsr_pkg::ADDR_SYS_CTL][sfsr_pkg::F_CORD];

    ////////////////////////////////////////////////////////////////////////
    // fault latches and status word
    sfsr_latch_if #(.N(sfsr_pkg::LATCH_N)) lat_if ();
    logic [sfsr_pkg::LATCH_N-1:0] clr_mon;
    logic [sfsr_pkg::LATCH_N-1:0] clr_sw;
    logic clr_all;
    logic clr_status;
    logic clr_fault_indicator_pin;
    logic por_flag;
    logic se_flag;
    logic [15:0] status;
    logic oc_a;
    logic oc_b;

    sfsr_fault_latch #(
        .N(sfsr_pkg::LATCH_N),
        .RST_VAL(sfsr_pkg::LATCH_N'(1) << sfsr_pkg::LAT_UV)
    ) u_latch (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .lat(lat_if.latch)
    );

    // mask bits: ot tw ov uv at 9..6, olb ola at 3..2, ocb oca at 1..0
    assign lat_if.raw = {switch_oc_i, monitor_fault_i};
    assign lat_if.mask = {{4{mask_reg[1]}}, {4{mask_reg[0]}}, mask_reg[9:6], mask_reg[3:2]};
    assign clr_mon = {{sfsr_pkg::SW_N{1'b0}}, {sfsr_pkg::MON_N{1'b1}}};
    assign clr_sw = ~clr_mon;
    // overcurrent summaries are views of the switch bits, never cleared apart
    assign lat_if.clr = ({sfsr_pkg::LATCH_N{clr_all | clr_status}} & clr_mon)
        | ({sfsr_pkg::LATCH_N{clr_all | clr_fault_indicator_pin}} & clr_sw);

    assign oc_a = |lat_if.q[9:6];
    assign oc_b = |lat_if.q[13:10];

    always_comb begin
        status = 16'h0000;
        status[sfsr_pkg::ST_POR] = por_flag;
        status[sfsr_pkg::ST_SE] = se_flag;
        status[sfsr_pkg::ST_CR] = command_accept_i;
        status[sfsr_pkg::ST_SSA] = sequence_active_i;
        status[sfsr_pkg::ST_OT] = lat_if.q[5];
        status[sfsr_pkg::ST_TW] = lat_if.q[4];
        status[sfsr_pkg::ST_OV] = lat_if.q[3];
        status[sfsr_pkg::ST_UV] = lat_if.q[2];
        status[sfsr_pkg::ST_OLB] = lat_if.q[1];
        status[sfsr_pkg::ST_OLA] = lat_if.q[0];
        status[sfsr_pkg::ST_OCB] = oc_b;
        status[sfsr_pkg::ST_OCA] = oc_a;
        // accept and active flags stay out of the summary
        status[sfsr_pkg::ST_FF] = por_flag | se_flag | (|status[10:1]);
    end

    ////////////////////////////////////////////////////////////////////////
    // frame engine
    logic [sfsr_pkg::CNT_W-1:0] bit_cnt;
    logic [15:0] rx_word;
    logic [3:0] rx_addr;
    logic rx_wr;
    logic frame_ok;
    logic frame_bad;
    logic wr_ok;
    logic reg_writable;
    logic prof_addr;

    assign rx_addr = rx_word[15:12];
    assign rx_wr = rx_word[11];
    // odd parity over the whole word, never stored
    assign frame_ok = cs_rise & (bit_cnt == 5'(sfsr_pkg::FRAME_BITS)) & (^rx_word);
    // no clock edges at all is a clean abandon, not an error
    assign frame_bad = cs_rise & (bit_cnt != 5'h00) & ~frame_ok;
    assign prof_addr = (rx_addr == sfsr_pkg::ADDR_STEP_CTL)
        | ((rx_addr >= sfsr_pkg::ADDR_PROF_LO) & (rx_addr <= sfsr_pkg::ADDR_PROF_HI));
    // diagnostic and readback are read only; profile writes need accept
    assign reg_writable = (rx_addr != sfsr_pkg::ADDR_FAULT_INDICATOR_PIN) & (rx_addr != sfsr_pkg::ADDR_READBACK)
        & ~(prof_addr & ~command_accept_i);
    assign wr_ok = frame_ok & rx_wr & reg_writable;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            bit_cnt <= 5'h00;
            rx_word <= 16'h0000;
        end else if (cs_fall) begin
            bit_cnt <= 5'h00;
        end else if (sck_rise) begin
            // saturating count so a long frame cannot wrap back to sixteen
            if (bit_cnt != 5'h1f) begin
                bit_cnt <= bit_cnt + 5'h01;
            end
            rx_word <= {rx_word[14:0], sdi_sync[1]};
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // output word and serial pin
    logic [15:0] out_word;
    logic out_loaded;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            out_word <= 16'h0000;
            out_loaded <= 1'b0;
        end else if (cs_fall) begin
            out_word <= status; // frame snapshot keeps the returned word coherent
            out_loaded <= 1'b0;
        end else if (bit_cnt == 5'(sfsr_pkg::HEAD_BITS) && !out_loaded && !sck_rise) begin
            out_loaded <= 1'b1;
            if (rx_word[0] || rx_word[4:1] == sfsr_pkg::ADDR_FAULT_INDICATOR_PIN) begin
                // write frames return status, diagnostic reads the switch bits
                out_word[10:0] <= rx_word[0] ? {out_word[10:1], ~^out_word[15:1]}
                    : {2'b00, lat_if.q[13:6], ~^{out_word[15:11], lat_if.q[13:6]}};
            end else begin
                out_word[10:0] <= {regs[rx_word[4:1]], ~^{out_word[15:11], regs[rx_word[4:1]]}};
            end
        end
    end

    logic [3:0] out_idx;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            out_idx <= 4'hf;
            serial_out_o <= 1'b0;
            serial_out_oe_n_o <= 1'b1;
        end else if (cs_sync[1]) begin
            out_idx <= 4'hf;
            serial_out_oe_n_o <= 1'b1;
        end else if (cs_fall) begin
            out_idx <= 4'hf;
            serial_out_o <= status[sfsr_pkg::ST_FF];
            serial_out_oe_n_o <= 1'b0;
        end else if (sck_fall && out_idx != 4'h0) begin
            out_idx <= out_idx - 4'h1;
            serial_out_o <= out_word[out_idx - 4'h1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register writes and clearing actions
    localparam int RST_CNT_W_L = 16;
    logic [RST_CNT_W_L-1:0] rst_cnt;
    logic fclr_rise;
    logic sleep_rise;
    logic pin_clear;

    // command bits act on their 0 to 1 transition only
    assign fclr_rise = wr_ok & (rx_addr == sfsr_pkg::ADDR_SYS_CTL) & rx_word[sfsr_pkg::F_FCLR + 1]
        & ~regs[sfsr_pkg::ADDR_SYS_CTL][sfsr_pkg::F_FCLR];
    assign sleep_rise = wr_ok & (rx_addr == sfsr_pkg::ADDR_SYS_CTL) & rx_word[sfsr_pkg::F_SLEEP + 1]
        & ~regs[sfsr_pkg::ADDR_SYS_CTL][sfsr_pkg::F_SLEEP];
    assign pin_clear = ~rstn_sync[1] & (rst_cnt >= RST_CNT_W_L'(RST_CYC));
    assign clr_all = fclr_rise | sleep_rise | pin_clear;
    // a good frame has shown the status word; reads clear unless disabled
    assign clr_status = frame_ok & ~cord_dis;
    assign clr_fault_indicator_pin = frame_ok & ~rx_wr & (rx_addr == sfsr_pkg::ADDR_FAULT_INDICATOR_PIN) & ~cord_dis;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rst_cnt <= '0;
        end else if (rstn_sync[1]) begin
            rst_cnt <= '0;
        end else if (rst_cnt != '1) begin
            rst_cnt <= rst_cnt + RST_CNT_W_L'(1);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 16; i++) begin
                regs[i] <= sfsr_pkg::RST_OTHER;
            end
            regs[sfsr_pkg::ADDR_CUR_CFG] <= sfsr_pkg::RST_CUR_CFG;
            regs[sfsr_pkg::ADDR_FAULT_INDICATOR_PIN_CFG] <= sfsr_pkg::RST_FAULT_INDICATOR_PIN_CFG;
            regs[sfsr_pkg::ADDR_SYS_CTL] <= sfsr_pkg::RST_SYS_CTL;
        end else if (wr_ok) begin
            regs[rx_addr] <= rx_word[10:1];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            por_flag <= 1'b1;
        end else if (clr_all || clr_status) begin
            por_flag <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            se_flag <= 1'b0;
        end else if (frame_bad) begin
            se_flag <= 1'b1;
        end else if (frame_ok || clr_all) begin
            se_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer strobe and indicator pin
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            profile_write_o <= 1'b0;
            fault_indicator_pin_o <= 1'b1;
        end else begin
            profile_write_o <= wr_ok & prof_addr;
            // active low on the pin in both uses
            fault_indicator_pin_o <= (dsel == sfsr_pkg::DSEL_SEQ) ? ~sequence_active_i
                : ~status[sfsr_pkg::ST_FF];
        end
    end
endmodule
`default_nettype wire

/* dv/sfsr_monitor.sv */
// Purpose: port checks of the stepper fault status block
// Assumes: host keeps select high at least 4 cycles between frames
// Notes: attached to the top by bind
`timescale 1ns/1ps
`default_nettype none
module sfsr_monitor (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // link
    input wire logic frame_select_n_i,
    input wire logic serial_clk_i,
    input wire logic serial_out_o,
    input wire logic serial_out_oe_n_o,
    // sequencer and pin
    input wire logic command_accept_i,
    input wire logic profile_write_o,
    input wire logic fault_indicator_pin_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////
    // six samples cover the select synchroniser plus the output register
    sequence s_idle;
        frame_select_n_i [*6];
    endsequence
    sequence s_sel;
        !frame_select_n_i [*6];
    endsequence
    sequence s_clk_hi;
        (serial_clk_i && !frame_select_n_i) [*5];
    endsequence
    ////////////////////////////////////////////////////////////////
    AST_RST_OUTS: assert property ($fell(rst_i) |->
        serial_out_oe_n_o && fault_indicator_pin_o && !profile_write_o)
        else $error("outputs not at reset values");
    AST_PIN_POR: assert property ($fell(rst_i) |-> ##[1:2] !fault_indicator_pin_o)
        else $error("indicator not low after reset");
    AST_OE_OFF: assert property (s_idle |-> serial_out_oe_n_o)
        else $error("serial out driven while deselected");
    AST_OE_ON: assert property (s_sel |-> !serial_out_oe_n_o)
        else $error("serial out released while selected");
    AST_SDO_HOLD: assert property (s_clk_hi |-> $stable(serial_out_o))
        else $error("serial out moved while clock high");
    AST_PW_ACC: assert property (profile_write_o |-> command_accept_i)
        else $error("profile write while not ready");
    AST_PW_ONE: assert property (profile_write_o |=> !profile_write_o)
        else $error("profile write longer than a cycle");
    AST_PW_IDLE: assert property (profile_write_o |-> frame_select_n_i && $past(frame_select_n_i))
        else $error("profile write inside a frame");
endmodule
bind sfsr_top sfsr_monitor u_sfsr_monitor (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .frame_select_n_i(frame_select_n_i),
    .serial_clk_i(serial_clk_i), .serial_out_o(serial_out_o), .serial_out_oe_n_o(serial_out_oe_n_o),
    .command_accept_i(command_accept_i), .profile_write_o(profile_write_o),
    .fault_indicator_pin_o(fault_indicator_pin_o));
`default_nettype wire

/* dv/sfsr_host_model.sv */
// Purpose: host side of the serial link
// Assumes: link clock idles low and stands still between frames
// Notes: no pull-up on the data out line
`timescale 1ns/1ps
`default_nettype none
module sfsr_host_model (
    // link pins
    output var logic frame_select_n_o,
    output var logic serial_clk_o,
    output var logic serial_in_o,
    input wire logic serial_out_i,
    input wire logic serial_out_oe_n_i
);
    logic last = 1'b0;
    logic line;
    initial begin
        frame_select_n_o = 1'b1;
        serial_clk_o = 1'b0;
        serial_in_o = 1'b0;
    end
    // a released line must not pass for the last bit, so it shows the inverse
    assign line = serial_out_oe_n_i ? ~last : serial_out_i;
    always @(serial_out_i or serial_out_oe_n_i) if (!serial_out_oe_n_i) last = serial_out_i;
    ////////////////////////////////////////////////////////////////
    // n of 0 abandons the frame cleanly; any other n than 16 breaks the frame on purpose
    task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
        r = 16'h0000;
        // an abandoned poll keeps the clock high while selected
        serial_clk_o = (n == 0);
        #62.5;
        frame_select_n_o = 1'b0;
        for (int i = 0; i < n; i++) begin
            serial_in_o = w[15 - i % 16];
            #62.5;
            r = {r[14:0], line};
            serial_clk_o = 1'b1;
            #62.5;
            serial_clk_o = 1'b0;
        end
        if (n == 0) begin
            #62.5;
            r = {15'h0000, line};
        end
        #62.5;
        frame_select_n_o = 1'b1;
        serial_in_o = ~serial_in_o;
        #62.5;
        serial_clk_o = 1'b0;
    endtask
endmodule
`default_nettype wire

/* dv/sfsr_top_tb.sv */
// Purpose: self-checking bench of the stepper fault status block
// Assumes: host model drives the link, bench drives monitors and sequencer
// Notes: reset pulse shortened to RCYC cycles
`timescale 1ns/1ps
`default_nettype none
module sfsr_top_tb;
    localparam int RCYC = 4;
    localparam logic [3:0] MK = sfsr_pkg::ADDR_MASK;
    localparam logic [3:0] DG = sfsr_pkg::ADDR_FAULT_INDICATOR_PIN;
    localparam logic [3:0] SC = sfsr_pkg::ADDR_SYS_CTL;
    localparam logic [3:0] DC = sfsr_pkg::ADDR_FAULT_INDICATOR_PIN_CFG;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hw_n = 1'b1;
    logic [5:0] mon = 6'h00;
    logic [7:0] sw = 8'h00;
    logic acc = 1'b0;
    logic act = 1'b0;
    logic sel_n, sclk, serial_in, serial_out, oe_n, pw, pin;
    logic por, se, cord, dseq;
    logic [5:0] lm, mm, v;
    logic [7:0] ls, sm;
    logic [9:0] p6;
    logic [15:0] r, w;
    int nclk[3] = '{15, 17, 16};
    int error_cnt = 0;
    int checked = 0;
    int pw_cnt = 0;
    int c0;
    always #5 clk = ~clk;
    always @(posedge clk) if (pw === 1'b1) pw_cnt++;
    sfsr_top #(.RST_CYC(RCYC)) u_sfsr_top (.sys_clk_i(clk), .rst_i(rst), .frame_select_n_i(sel_n),
        .serial_clk_i(sclk), .serial_in_i(serial_in), .serial_out_o(serial_out), .serial_out_oe_n_o(oe_n),
        .hw_reset_input_low_i(hw_n), .monitor_fault_i(mon), .switch_oc_i(sw), .command_accept_i(acc),
        .sequence_active_i(act), .profile_write_o(pw), .fault_indicator_pin_o(pin));
    sfsr_host_model u_sfsr_host_model (.frame_select_n_o(sel_n), .serial_clk_o(sclk), .serial_in_o(serial_in),
        .serial_out_i(serial_out), .serial_out_oe_n_i(oe_n));
    ////////////////////////////////////////////////////////////////
    function automatic logic [15:0] par(input logic [15:0] x);
        return {x[15:1], ~^x[15:1]};
    endfunction
    function automatic logic [15:0] stv();
        logic [13:0] b;
        b = {por, se, acc, act, lm[5:2], 2'b00, lm[1:0], |ls[7:4], |ls[3:0]};
        return {por | se | (|lm) | (|ls), b, 1'b0};
    endfunction
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic settle();
        repeat (10) @(posedge clk);
        #1;
    endtask
    task automatic do_rst();
        @(posedge clk);
        #1;
        rst = 1'b1;
        repeat (10) @(posedge clk);
        #1;
        rst = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        {por, se, cord, dseq, lm, mm, ls, sm, p6} = {4'b1000, 6'h04, 6'h00, 16'h0000, sfsr_pkg::RST_SYS_CTL};
    endtask
    // one-cycle fault pulse; keep stays present afterwards
    task automatic hit(input logic [5:0] m, input logic [7:0] s, input logic [5:0] keep);
        @(posedge clk);
        #1;
        mon = m;
        sw = s;
        @(posedge clk);
        #1;
        mon = keep;
        sw = 8'h00;
        lm = lm | (m & ~mm);
        ls = ls | (s & ~sm);
    endtask
    task automatic xf(input logic [3:0] a, input logic wr, input logic [9:0] d, input logic [9:0] rd);
        logic [15:0] s;
        s = stv();
        u_sfsr_host_model.xfer(par({a, wr, d, 1'b0}), 16, r);
        settle();
        chk("frame", r, wr ? par(s) : par({s[15:11], rd, 1'b0}));
        chk("oe_n", {15'h0000, oe_n}, 16'h0001);
        se = 1'b0;
        if (!cord) begin
            por = 1'b0;
            lm = lm & mon & ~mm;
            if (!wr && a == DG) ls = ls & sw & ~sm;
        end
        if (wr && a == MK) {mm, sm} = {d[9:6], d[3:2], {4{d[1]}}, {4{d[0]}}};
        if (wr && a == SC) begin
            // only a rising command bit clears
            if ((d[8] && !p6[8]) || (d[9] && !p6[9])) {lm, ls} = {mon & ~mm, sw & ~sm};
            p6 = d;
            cord = d[3];
        end
        if (wr && a == DC) dseq = (d[9:7] == sfsr_pkg::DSEL_SEQ);
        s = stv();
        chk("pin", {15'h0000, pin}, {15'h0000, dseq ? ~act : ~s[15]});
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        #500000;
        error_cnt++;
        end_of_test();
    end
    initial begin
        c0 = $urandom(32'h3109);
        do_rst();
        xf(sfsr_pkg::ADDR_CUR_CFG, 1'b0, 10'h000, sfsr_pkg::RST_CUR_CFG);
        xf(DC, 1'b0, 10'h000, sfsr_pkg::RST_FAULT_INDICATOR_PIN_CFG);
        xf(SC, 1'b0, 10'h000, sfsr_pkg::RST_SYS_CTL);
        for (int k = 0; k < 6; k++) begin
            v = 6'(1 << k) | 6'($urandom);
            hit(v, 8'h00, v & 6'($urandom));
            xf(MK, 1'b0, 10'h000, 10'h000);
            xf(MK, 1'b1, 10'h000, 10'h000);
            mon = 6'h00;
        end
        hit(6'h00, 8'($urandom) | 8'h10, 6'h00);
        xf(MK, 1'b0, 10'h000, 10'h000);
        xf(DG, 1'b1, 10'($urandom), 10'h000);
        xf(DG, 1'b0, 10'h000, {2'b00, ls});
        xf(MK, 1'b0, 10'h000, 10'h000);
        xf(MK, 1'b1, 10'h3cf, 10'h000);
        hit(6'h3f, 8'hff, 6'h00);
        xf(MK, 1'b0, 10'h000, 10'h3cf);
        xf(MK, 1'b1, 10'h000, 10'h000);
        for (int k = 0; k < 3; k++) begin
            w = par({MK, 1'b1, 10'h3ff, 1'b0});
            w[0] = w[0] ^ (k == 2);
            u_sfsr_host_model.xfer(w, nclk[k], r);
            settle();
            se = 1'b1;
            xf(MK, 1'b0, 10'h000, 10'h000);
        end
        hit(6'h20, 8'h00, 6'h00);
        u_sfsr_host_model.xfer(16'h0000, 0, r);
        settle();
        chk("summary", r, 16'h0001);
        xf(MK, 1'b0, 10'h000, 10'h000);
        xf(SC, 1'b1, 10'h008, 10'h000);
        hit(6'h01, 8'h00, 6'h00);
        xf(MK, 1'b0, 10'h000, 10'h000);
        xf(SC, 1'b1, 10'h108, 10'h000);
        hit(6'h02, 8'h00, 6'h00);
        xf(SC, 1'b1, 10'h108, 10'h000);
        xf(SC, 1'b1, 10'h208, 10'h000);
        hit(6'h08, 8'h01, 6'h00);
        hw_n = 1'b0;
        repeat (RCYC + 6) @(posedge clk);
        #1;
        hw_n = 1'b1;
        settle();
        {lm, ls} = 14'h0000;
        xf(SC, 1'b1, 10'h000, 10'h000);
        xf(DC, 1'b1, 10'h300, 10'h000);
        for (int k = 0; k < 4; k++) begin
            act = k[0];
            xf(MK, 1'b0, 10'h000, 10'h000);
        end
        xf(DC, 1'b1, sfsr_pkg::RST_FAULT_INDICATOR_PIN_CFG, 10'h000);
        for (int a = 5; a < 13; a++) begin
            acc = a[0];
            c0 = pw_cnt;
            if (a != 6) xf(4'(a), 1'b1, 10'($urandom), 10'h000);
            chk("profile", 16'(pw_cnt - c0), {15'h0000, acc && a != 6});
        end
        do_rst();
        xf(SC, 1'b0, 10'h000, sfsr_pkg::RST_SYS_CTL);
        end_of_test();
    end
endmodule
`default_nettype wire
